/* rtl/pmc_pkg.sv */
// ============================================================
// How it works
// - Level and mode combine into three states; handler never runs at user
// - Handler mode, privileged, for exceptions; thread mode otherwise
// - User level blocks restricted accesses; each attempt raises a fault
// - Privileged level allows every register access without fault; legacy and size-0 encodings fault at any level
// - Separate main and process stack pointers are held
// - Only 16-bit and 32-bit compact encodings decode; legacy set faults
// - 4 GB map with code, data, peripheral regions
// - Bit-band alias decodes to an SRAM word address and bit number
// - Unaligned loads are merged from two words by the data path; word-crossing accesses are flagged
// - Control bit 0 selects thread privilege, bit 1 selects stack
// - Process stack only at user thread; stack bit zero in handler
// - Banked stack pointer low two bits are forced to zero
// ============================================================
package pmc_pkg;
    localparam int          ADDR_W        = 32;
    localparam logic [1:0]  CTRL_RESET    = 2'h0;
    localparam int          CTRL_NPRIV    = 0;
    localparam int          CTRL_SPSEL    = 1;
    localparam logic [31:0] SP_RESET      = 32'h0000_0000;
    localparam logic [31:0] SP_ALIGN_MASK = 32'hFFFF_FFFC;
    // Address region bases (top bits)
    localparam logic [2:0]  REG_CODE      = 3'h0;
    localparam logic [2:0]  REG_SRAM      = 3'h1;
    localparam logic [2:0]  REG_PERIPH    = 3'h2;
    // Bit-band windows
    localparam logic [31:0] BB_SRAM_BASE  = 32'h2000_0000;
    localparam logic [31:0] BB_ALIAS_BASE = 32'h2200_0000;
    localparam logic [31:0] BB_ALIAS_END  = 32'h23FF_FFFF;
    // Instruction width codes
    localparam logic [1:0]  ISZ_16        = 2'h1;
    localparam logic [1:0]  ISZ_32        = 2'h2;
    localparam logic [1:0]  ISZ_LEGACY    = 2'h3;
    // Combined operating state
    typedef enum logic [1:0] {
        PMC_PRIV_THREAD,
        PMC_USER_THREAD,
        PMC_PRIV_HANDLER
    } pmc_state_t;
endpackage

/* rtl/pmc_lane_merge.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Unaligned lane shifter
module pmc_lane_merge #(
    parameter int W = 32
) (
    input  wire logic [W-1:0]   word_lo_in,
    input  wire logic [W-1:0]   word_hi_in,
    input  wire logic [1:0]     byte_off_in,
    output logic      [W-1:0]   data_out
);
    logic [2*W-1:0] both;
    // Concatenate and shift right by byte offset
    always_comb begin
        both     = {word_hi_in, word_lo_in} >> {byte_off_in, 3'h0};
        data_out = both[W-1:0];
    end
endmodule
`default_nettype wire

/* rtl/pmc_core_mode.sv */
`timescale 1ns/1ps
`default_nettype none
module pmc_core_mode (
    input  wire logic        core_clk_in,
    input  wire logic        srst_in,
    input  wire logic        ce_in,
    input  wire logic        exc_entry_in,
    input  wire logic        exc_return_in,
    input  wire logic        ctrl_wr_in,
    input  wire logic [1:0]  ctrl_wdata_in,
    input  wire logic        sp_wr_in,
    input  wire logic [31:0] sp_wdata_in,
    input  wire logic        msp_wr_in,
    input  wire logic        psp_wr_in,
    input  wire logic        restricted_in,
    input  wire logic        instr_valid_in,
    input  wire logic [1:0]  instr_size_in,
    input  wire logic        mem_req_in,
    input  wire logic [31:0] mem_addr_in,
    input  wire logic [1:0]  mem_size_in,
    input  wire logic [31:0] mem_word_lo_in,
    input  wire logic [31:0] mem_word_hi_in,
    input  wire logic        bb_wdata_in,
    output logic [1:0]       ctrl_out,
    output logic [1:0]       state_out,
    output logic             handler_out,
    output logic             user_out,
    output logic             psp_active_out,
    output logic [31:0]      sp_out,
    output logic [31:0]      main_stack_pointer_out,
    output logic [31:0]      process_stack_pointer_out,
    output logic             fault_out,
    output logic             instr_accept_out,
    output logic [2:0]       region_out,
    output logic             bb_hit_out,
    output logic [31:0]      bb_word_addr_out,
    output logic [4:0]       bb_bit_out,
    output logic             bb_wdata_out,
    output logic             unaligned_out,
    output logic [31:0]      load_data_out
);
    // ========================================================
    // Mode state
    logic [1:0]  ctrl_q;
    logic        handler_q;
    logic [31:0] main_stack_pointer_q;
    logic [31:0] process_stack_pointer_q;
    logic        fault_q;
    logic        privileged;
    logic        psp_active;

    // Privileged unless user bit set in thread mode
    assign privileged = handler_q | ~ctrl_q[pmc_pkg::CTRL_NPRIV];
    // Process stack only for a user-level thread with the stack bit set
    assign psp_active = ~privileged & ctrl_q[pmc_pkg::CTRL_SPSEL];

    // Handler on exception entry, thread on return
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            handler_q <= 1'b0;
        end else if (ce_in) begin
            if (exc_entry_in) begin
                handler_q <= 1'b1;
            end else if (exc_return_in) begin
                handler_q <= 1'b0;
            end
        end
    end

    // Control bits; only privileged writes, stack bit cleared in handler
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            ctrl_q <= pmc_pkg::CTRL_RESET;
        end else if (ce_in) begin
            if (ctrl_wr_in && privileged && !exc_entry_in) begin
                ctrl_q[pmc_pkg::CTRL_NPRIV] <=
                    ctrl_wdata_in[pmc_pkg::CTRL_NPRIV];
                ctrl_q[pmc_pkg::CTRL_SPSEL] <= ~handler_q
                    & ctrl_wdata_in[pmc_pkg::CTRL_SPSEL];
            end else if (exc_entry_in) begin
                ctrl_q[pmc_pkg::CTRL_SPSEL] <= 1'b0;
            end
        end
    end

    // Two banked stack pointers, word aligned
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            main_stack_pointer_q    <= pmc_pkg::SP_RESET;
            process_stack_pointer_q <= pmc_pkg::SP_RESET;
        end else if (ce_in) begin
            if ((sp_wr_in && !psp_active) || (msp_wr_in && privileged)) begin
                main_stack_pointer_q <=
                    sp_wdata_in & pmc_pkg::SP_ALIGN_MASK;
            end
            if ((sp_wr_in && psp_active) || (psp_wr_in && privileged)) begin
                process_stack_pointer_q <=
                    sp_wdata_in & pmc_pkg::SP_ALIGN_MASK;
            end
        end
    end

    // Fault pulse on blocked access, legacy encoding or size-0 encoding
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            fault_q <= 1'b0;
        end else if (ce_in) begin
            fault_q <= (restricted_in & ~privileged)
                     | (!privileged & (ctrl_wr_in | msp_wr_in | psp_wr_in))
                     | (instr_valid_in
                        & (instr_size_in == pmc_pkg::ISZ_LEGACY
                           || instr_size_in == 2'h0));
        end
    end

    // ========================================================
    // Memory side
    logic [31:0] bb_off;
    logic        bb_hit;
    logic [31:0] merged_q;
    logic [31:0] merged;
    logic        unaligned_q;

    assign bb_hit = mem_req_in && mem_addr_in >= pmc_pkg::BB_ALIAS_BASE
                    && mem_addr_in <= pmc_pkg::BB_ALIAS_END;
    assign bb_off = mem_addr_in - pmc_pkg::BB_ALIAS_BASE;

    // Bit-band alias decode, registered
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            bb_hit_out       <= 1'b0;
            bb_word_addr_out <= 32'h0000_0000;
            bb_bit_out       <= 5'h00;
            bb_wdata_out     <= 1'b0;
        end else if (ce_in) begin
            bb_hit_out       <= bb_hit;
            bb_word_addr_out <= pmc_pkg::BB_SRAM_BASE
                              + {10'h000, bb_off[26:7], 2'h0};
            bb_bit_out       <= bb_off[6:2];
            bb_wdata_out     <= bb_wdata_in;
        end
    end

    // Region decode, registered from top three address bits
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            region_out <= pmc_pkg::REG_CODE;
        end else if (ce_in) begin
            region_out <= mem_addr_in[31:29];
        end
    end

    pmc_lane_merge #(
        .W (pmc_pkg::ADDR_W)
    ) u_merge (
        .word_lo_in  (mem_word_lo_in),
        .word_hi_in  (mem_word_hi_in),
        .byte_off_in (mem_addr_in[1:0]),
        .data_out    (merged)
    );

    // Unaligned load result and split flag
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            merged_q    <= 32'h0000_0000;
            unaligned_q <= 1'b0;
        end else if (ce_in) begin
            merged_q    <= merged;
            unaligned_q <= mem_req_in && ({1'b0, mem_addr_in[1:0]}
                           + {1'b0, (mem_size_in == 2'h2) ? 2'h3
                              : (mem_size_in == 2'h1) ? 2'h1 : 2'h0})
                           > 3'h3;
        end
    end

    // Outputs
    assign ctrl_out                  = ctrl_q;
    assign handler_out               = handler_q;
    assign user_out                  = ~privileged;
    assign psp_active_out            = psp_active;
    assign sp_out = psp_active ? process_stack_pointer_q
                               : main_stack_pointer_q;
    assign main_stack_pointer_out    = main_stack_pointer_q;
    assign process_stack_pointer_out = process_stack_pointer_q;
    assign fault_out                 = fault_q;
    assign instr_accept_out = instr_valid_in
        && (instr_size_in == pmc_pkg::ISZ_16
            || instr_size_in == pmc_pkg::ISZ_32);
    assign unaligned_out             = unaligned_q;
    assign load_data_out             = merged_q;
    assign state_out = handler_q ? 2'(pmc_pkg::PMC_PRIV_HANDLER)
                     : privileged ? 2'(pmc_pkg::PMC_PRIV_THREAD)
                     : 2'(pmc_pkg::PMC_USER_THREAD);

    // ========================================================
    // Checks
    property p_no_user_handler;
        @(posedge core_clk_in) disable iff (srst_in)
        handler_out |-> !user_out;
    endproperty
    a_no_user_handler: assert property (p_no_user_handler)
        else $error("handler at user level");

    property p_entry;
        @(posedge core_clk_in) disable iff (srst_in)
        ce_in && exc_entry_in |=> handler_out && !psp_active_out;
    endproperty
    a_entry: assert property (p_entry)
        else $error("exception entry missed");

    property p_user_fault;
        @(posedge core_clk_in) disable iff (srst_in)
        ce_in && restricted_in && user_out |=> fault_out;
    endproperty
    a_user_fault: assert property (p_user_fault)
        else $error("user access not faulted");

    property p_priv_ok;
        @(posedge core_clk_in) disable iff (srst_in)
        ce_in && !user_out && !instr_valid_in |=> !fault_out;
    endproperty
    a_priv_ok: assert property (p_priv_ok)
        else $error("privileged access faulted");

    property p_legacy;
        @(posedge core_clk_in) disable iff (srst_in)
        instr_valid_in && instr_size_in == 2'h3 |-> !instr_accept_out;
    endproperty
    a_legacy: assert property (p_legacy)
        else $error("legacy encoding accepted");

    property p_sp_align;
        @(posedge core_clk_in) disable iff (srst_in)
        sp_out[1:0] == 2'h0;
    endproperty
    a_sp_align: assert property (p_sp_align)
        else $error("stack pointer misaligned");

    property p_sp_sel;
        @(posedge core_clk_in) disable iff (srst_in)
        handler_out |-> sp_out == main_stack_pointer_out;
    endproperty
    a_sp_sel: assert property (p_sp_sel)
        else $error("process stack in handler");

    property p_psp_user;
        @(posedge core_clk_in) disable iff (srst_in)
        psp_active_out |-> user_out && sp_out == process_stack_pointer_out;
    endproperty
    a_psp_user: assert property (p_psp_user)
        else $error("process stack outside user thread");

    property p_reset;
        @(posedge core_clk_in) srst_in |=> ctrl_out == 2'h0 && !handler_out;
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset state wrong");
endmodule
`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        core_clk_in, srst_in, ce_in, exc_entry_in, exc_return_in;
    logic        ctrl_wr_in, sp_wr_in, msp_wr_in, psp_wr_in, restricted_in;
    logic        instr_valid_in, mem_req_in, bb_wdata_in;
    logic [1:0]  ctrl_wdata_in, instr_size_in, mem_size_in;
    logic [31:0] sp_wdata_in, mem_addr_in, mem_word_lo_in, mem_word_hi_in;
    logic [1:0]  ctrl_out, state_out;
    logic        handler_out, user_out, psp_active_out, fault_out;
    logic        instr_accept_out, bb_hit_out, bb_wdata_out, unaligned_out;
    logic [31:0] sp_out, main_stack_pointer_out, process_stack_pointer_out;
    logic [31:0] bb_word_addr_out, load_data_out;
    logic [2:0]  region_out;
    logic [4:0]  bb_bit_out;
    int          errors, n_checks, cycles;
    // ============================================================
    // Device under test
    pmc_core_mode dut_u (
        .core_clk_in, .srst_in, .ce_in, .exc_entry_in, .exc_return_in,
        .ctrl_wr_in, .ctrl_wdata_in, .sp_wr_in, .sp_wdata_in, .msp_wr_in,
        .psp_wr_in, .restricted_in, .instr_valid_in, .instr_size_in,
        .mem_req_in, .mem_addr_in, .mem_size_in, .mem_word_lo_in,
        .mem_word_hi_in, .bb_wdata_in, .ctrl_out, .state_out, .handler_out,
        .user_out, .psp_active_out, .sp_out, .main_stack_pointer_out,
        .process_stack_pointer_out, .fault_out, .instr_accept_out,
        .region_out, .bb_hit_out, .bb_word_addr_out, .bb_bit_out,
        .bb_wdata_out, .unaligned_out, .load_data_out
    );
    // Clock and hang guard
    initial begin
        core_clk_in = 1'b0;
        forever #4 core_clk_in = ~core_clk_in;
    end
    always @(posedge core_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            errors++;
            tally_and_finish();
        end
    end
    // ============================================================
    // Shared helpers
    task automatic check(input string nm, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick();
        @(negedge core_clk_in);
    endtask
    task automatic do_reset();
        tick();
        srst_in = 1'b1;
        repeat (3) tick();
        srst_in = 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ============================================================
    // Scenarios
    task automatic t_reset_and_stacks();
        do_reset();
        check("ctrl", ctrl_out, 2'h0);
        check("state", state_out, pmc_pkg::PMC_PRIV_THREAD);
        check("sp", sp_out, 32'h0);
        msp_wr_in = 1'b1;
        sp_wdata_in = 32'h1000_0007;
        restricted_in = 1'b1;
        tick();
        msp_wr_in = 1'b0;
        psp_wr_in = 1'b1;
        sp_wdata_in = 32'h2000_00FE;
        tick();
        psp_wr_in = 1'b0;
        restricted_in = 1'b0;
        check("fault", fault_out, 1'b0);
        check("msp", main_stack_pointer_out, 32'h1000_0004);
        check("psp", process_stack_pointer_out, 32'h2000_00FC);
        check("sp", sp_out, 32'h1000_0004);
        ctrl_wr_in = 1'b1;
        ctrl_wdata_in = 2'h2;
        tick();
        check("ctrl", ctrl_out, 2'h2);
        check("psp_active", psp_active_out, 1'b0);
        check("sp", sp_out, 32'h1000_0004);
        ce_in = 1'b0;
        ctrl_wdata_in = 2'h3;
        tick();
        check("ctrl", ctrl_out, 2'h2);
        ce_in = 1'b1;
        tick();
        ctrl_wr_in = 1'b0;
        check("ctrl", ctrl_out, 2'h3);
        check("state", state_out, pmc_pkg::PMC_USER_THREAD);
        check("psp_active", psp_active_out, 1'b1);
        check("sp", sp_out, 32'h2000_00FC);
        restricted_in = 1'b1;
        tick();
        restricted_in = 1'b0;
        check("fault", fault_out, 1'b1);
        ctrl_wr_in = 1'b1;
        ctrl_wdata_in = 2'h0;
        tick();
        ctrl_wr_in = 1'b0;
        check("fault", fault_out, 1'b1);
        check("ctrl", ctrl_out, 2'h3);
        sp_wr_in = 1'b1;
        sp_wdata_in = 32'h3000_0013;
        tick();
        sp_wr_in = 1'b0;
        check("psp", process_stack_pointer_out, 32'h3000_0010);
        check("msp", main_stack_pointer_out, 32'h1000_0004);
        exc_entry_in = 1'b1;
        tick();
        exc_entry_in = 1'b0;
        check("handler", handler_out, 1'b1);
        check("user", user_out, 1'b0);
        check("state", state_out, pmc_pkg::PMC_PRIV_HANDLER);
        check("ctrl1", ctrl_out[1], 1'b0);
        check("sp", sp_out, 32'h1000_0004);
        ctrl_wr_in = 1'b1;
        ctrl_wdata_in = 2'h3;
        restricted_in = 1'b1;
        tick();
        ctrl_wr_in = 1'b0;
        restricted_in = 1'b0;
        check("ctrl", ctrl_out, 2'h1);
        check("fault", fault_out, 1'b0);
        exc_return_in = 1'b1;
        tick();
        exc_return_in = 1'b0;
        check("handler", handler_out, 1'b0);
        check("state", state_out, pmc_pkg::PMC_USER_THREAD);
    endtask
    task automatic t_instr();
        do_reset();
        instr_valid_in = 1'b1;
        for (int s = 0; s < 4; s++) begin
            instr_size_in = 2'(s);
            #1;
            check("accept", instr_accept_out, s == 1 || s == 2);
            tick();
            check("fault", fault_out, s == 0 || s == 3);
        end
        instr_valid_in = 1'b0;
    endtask
    task automatic mem_case(input logic [31:0] a, input logic [1:0] sz,
                            input logic [2:0] rg, input logic hit, un,
                            input logic [31:0] wd, dat);
        mem_req_in = 1'b1;
        mem_addr_in = a;
        mem_size_in = sz;
        tick();
        check("region", region_out, rg);
        check("bb_hit", bb_hit_out, hit);
        check("unaligned", unaligned_out, un);
        check("load", load_data_out, dat);
        if (hit) begin
            check("bb_word", bb_word_addr_out, wd);
            check("bb_bit", bb_bit_out, 5'h01);
            check("bb_wdata", bb_wdata_out, 1'b1);
        end
    endtask
    // ============================================================
    // Main sequence
    initial begin
        srst_in = 1'b1;
        {exc_entry_in, exc_return_in, ctrl_wr_in} = '0;
        {sp_wr_in, msp_wr_in, psp_wr_in, restricted_in} = '0;
        {instr_valid_in, mem_req_in, ctrl_wdata_in, instr_size_in} = '0;
        {sp_wdata_in, mem_addr_in, mem_size_in} = '0;
        ce_in = 1'b1;
        bb_wdata_in = 1'b1;
        mem_word_lo_in = 32'h4433_2211;
        mem_word_hi_in = 32'h8877_6655;
        errors = 0;
        n_checks = 0;
        cycles = 0;
        t_reset_and_stacks();
        t_instr();
        mem_case(32'h2200_0084, 2'h2, 3'h1, 1'b1, 1'b0, 32'h2000_0004,
                 32'h4433_2211);
        mem_case(32'h4000_0001, 2'h2, 3'h2, 1'b0, 1'b1, 32'h0,
                 32'h5544_3322);
        mem_case(32'h0000_0003, 2'h0, 3'h0, 1'b0, 1'b0, 32'h0,
                 32'h7766_5544);
        mem_req_in = 1'b0;
        tally_and_finish();
    end
endmodule
`default_nettype wire
